// ### hdl/dcc_code_path.sv
// Calibrated code path: gain/offset trim, span select, supply alarm.
// Assumes supply comparators arrive asynchronously; host writes are synchronous.
//
// Operation
// - Gain factor is one half plus trim code over two to the N.
// - Offset trim is two's complement, top bit weighs negative.
// - Calibrated code equals output code times gain plus offset.
// - Trim changes take effect only at the next output code write.
// - Gain trim left justified; 14-bit variant ignores two low bits.
// - Offset trim left justified; 14-bit variant discards two low bits.
// - Calibrated code is N bits, zero up to two to N minus one.
// - Span bit zero selects full span, one selects narrow span.
// - In clear state span follows the clear-state span bit.
// - Supply not in exactly one band, whatever the span, raises alarm and applies fault action.
// - Gain multiply truncates rather than rounds.
// - Output code left justified; 14-bit variant ignores two low bits.
// - Clear state drives converter from safe-state code.
`timescale 1ns/1ns
`default_nettype none
module dcc_code_path
	import dcc_pkg::*;
#(
	parameter int N = DCC_FULL_BITS
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic codeWrite,
	input wire logic [15:0] outputCode,
	input wire dcc_trim_s trimIn,
	input wire logic spanSelect,
	input wire logic clear_span_select,
	input wire logic clearState,
	input wire logic [15:0] safe_state_code,
	input wire logic [1:0] fault_action_config,
	input wire dcc_supply_s main_supply,
	output logic [15:0] convCode,
	output logic convUpdate,
	output logic narrowSpan,
	output logic supplyAlarm,
	output logic [1:0] faultActionOut,
	output logic [1:0] supplyBand
);
	localparam int DROP = (N == DCC_FULL_BITS) ? 0 : int'(DCC_DROP_LSBS);
	localparam int W = DCC_FULL_BITS - DROP;
	localparam logic [15:0] CODE_MAX = 16'((1 << W) - 1);

	////////////////////////////////////////////////////////////////////////////
	// Supply band detection
	dcc_supply_s supMeta_reg;
	dcc_supply_s supSync_reg;
	dcc_band_e band_next;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			supMeta_reg <= '0;
			supSync_reg <= '0;
		end else begin
			supMeta_reg <= main_supply;
			supSync_reg <= supMeta_reg;
		end
	end
	always_comb begin
		case ({supSync_reg.highBandOk, supSync_reg.lowBandOk})
			2'b01: band_next = DCC_BAND_LOW;
			2'b10: band_next = DCC_BAND_HIGH;
			default: band_next = DCC_BAND_BAD;
		endcase
	end
	logic alarm_next;
	assign alarm_next = (band_next == DCC_BAND_BAD);
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			supplyAlarm <= 1'b0;
			faultActionOut <= 2'h0;
			supplyBand <= DCC_BAND_BAD;
		end else begin
			supplyAlarm <= alarm_next;
			faultActionOut <= alarm_next ? fault_action_config : 2'h0;
			supplyBand <= band_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Span selection
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			narrowSpan <= DCC_SPAN_FULL;
		end else begin
			narrowSpan <= clearState ? clear_span_select : spanSelect;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Calibration arithmetic
	logic [W-1:0] dataN;
	logic [W-1:0] gainN;
	logic signed [W-1:0] offsetN;
	logic [2*W:0] product;
	logic signed [W+2:0] sumVal;
	logic [15:0] calCode;
	assign dataN = outputCode[15 -: W];
	assign gainN = trimIn.gainTrim[15 -: W];
	assign offsetN = trimIn.offsetTrim[15 -: W];
	// Data times (2^(N-1) + gain) over 2^N, low bits dropped
	assign product = {1'b0, dataN} * ({1'b0, gainN} + (W+1)'(1 << (W-1)));
	assign sumVal = $signed({1'b0, product[2*W:W]}) + (W+3)'(offsetN);
	always_comb begin
		calCode = '0;
		if (sumVal < 0) begin
			calCode = '0;
		end else if (sumVal > $signed((W+3)'((1 << W) - 1))) begin
			calCode = 16'((1 << W) - 1);
		end else begin
			calCode = 16'(sumVal[W-1:0]);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Converter code register
	logic [15:0] safeN;
	logic clearSeen_reg;
	assign safeN = 16'(safe_state_code[15 -: W]);
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			convCode <= DCC_CODE_RESET;
			convUpdate <= 1'b0;
			clearSeen_reg <= 1'b0;
		end else begin
			clearSeen_reg <= clearState;
			convUpdate <= 1'b0;
			if (clearState) begin
				convCode <= safeN;
				convUpdate <= !clearSeen_reg;
			end else if (codeWrite) begin
				convCode <= calCode;
				convUpdate <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence writeSeq;
		codeWrite && !clearState;
	endsequence
	sequence loadSeq;
		convUpdate && (convCode == $past(calCode));
	endsequence
	code_load_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		writeSeq |=> loadSeq)
		else $error("code not loaded after write");
	code_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(!codeWrite && !clearState) |=> $stable(convCode))
		else $error("code changed without write");
	safe_code_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		clearState |=> convCode == $past(safeN))
		else $error("clear state not using safe code");
	span_sel_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		!clearState |=> narrowSpan == $past(spanSelect))
		else $error("span select mismatch");
	clear_span_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		clearState |=> narrowSpan == $past(clear_span_select))
		else $error("clear span mismatch");
	supply_alarm_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(supSync_reg.lowBandOk == supSync_reg.highBandOk) |=> supplyAlarm)
		else $error("alarm not raised");
	code_range_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		convCode <= CODE_MAX)
		else $error("code above range");
	unity_gain_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(writeSeq and (trimIn.gainTrim == DCC_GAIN_UNITY)
			and (trimIn.offsetTrim == DCC_OFFSET_ZERO))
		|=> convCode == 16'($past(dataN)))
		else $error("unity gain not identity");
	sequence clearEntrySeq;
		clearState && !clearSeen_reg;
	endsequence
	sequence clearStaySeq;
		clearState && clearSeen_reg;
	endsequence
	sat_low_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(writeSeq and (sumVal < 0)) |=> convCode == 16'h0000)
		else $error("negative result not clamped");
	sat_high_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(writeSeq and (sumVal > $signed({3'b000, CODE_MAX[W-1:0]})))
		|=> convCode == CODE_MAX)
		else $error("large result not clamped");
	idle_update_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(!codeWrite && !clearState) |=> !convUpdate)
		else $error("update pulse without write");
	clear_pulse_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		clearEntrySeq |=> convUpdate)
		else $error("no update on clear entry");
	clear_quiet_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		clearStaySeq |=> !convUpdate)
		else $error("repeated update in clear state");

	////////////////////////////////////////////////////////////////////////////
	// Supply and fault checks
	sequence badSupplySeq;
		main_supply.lowBandOk == main_supply.highBandOk;
	endsequence
	sequence goodSupplySeq;
		main_supply.lowBandOk != main_supply.highBandOk;
	endsequence
	alarm_delay_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		badSupplySeq |-> ##3 supplyAlarm)
		else $error("alarm late after supply fault");
	alarm_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		goodSupplySeq |-> ##3 !supplyAlarm)
		else $error("alarm with valid supply");
	band_bad_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		badSupplySeq |-> ##3 (supplyBand == DCC_BAND_BAD))
		else $error("bad band not reported");
	band_low_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(main_supply.lowBandOk && !main_supply.highBandOk) |-> ##3 (supplyBand == DCC_BAND_LOW))
		else $error("low band not reported");
	band_high_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(!main_supply.lowBandOk && main_supply.highBandOk) |-> ##3 (supplyBand == DCC_BAND_HIGH))
		else $error("high band not reported");
	fault_idle_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		!supplyAlarm |-> faultActionOut == 2'h0)
		else $error("fault action without alarm");
	fault_copy_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		supplyAlarm |-> faultActionOut == $past(fault_action_config))
		else $error("fault action not applied");
endmodule : dcc_code_path
`default_nettype wire

// ### hdl/dcc_pkg.sv
// Constants and carriers for the calibrated converter code path.
// Assumes a single system clock domain.
`default_nettype none
package dcc_pkg;
	localparam int DCC_FULL_BITS = 16;
	localparam int DCC_LOW_BITS = 14;
	localparam logic [1:0] DCC_DROP_LSBS = 2'h2;
	localparam logic [15:0] DCC_GAIN_UNITY = 16'h8000;
	localparam logic [15:0] DCC_OFFSET_ZERO = 16'h0000;
	localparam logic [15:0] DCC_CODE_RESET = 16'h0000;
	localparam logic DCC_SPAN_FULL = 1'b0;
	localparam logic DCC_SPAN_NARROW = 1'b1;

	typedef enum logic [1:0] {
		DCC_BAND_LOW = 2'b00,
		DCC_BAND_HIGH = 2'b01,
		DCC_BAND_BAD = 2'b10
	} dcc_band_e;

	typedef struct packed {
		logic [15:0] gainTrim;
		logic [15:0] offsetTrim;
	} dcc_trim_s;

	typedef struct packed {
		logic lowBandOk;
		logic highBandOk;
	} dcc_supply_s;
endpackage : dcc_pkg
`default_nettype wire

// ### tb/dcc_code_path_tb.sv
// Self-checking bench for the calibrated code path.
// Assumes the path at N of 16 and of 14, one 25 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module dcc_code_path_tb;
	import dcc_pkg::*;
	logic sys_clk = 0, rstn = 0, codeWrite = 0, spanSelect = 0, clearState = 0;
	logic clear_span_select = 1, convUpdate, narrowSpan, supplyAlarm;
	logic [15:0] outputCode = 0, safe_state_code = 16'h1234, convCode, heldCode, d, g, last;
	logic [15:0] convCode14, last14;
	logic [1:0] fault_action_config = 2'h0, faultActionOut, supplyBand;
	dcc_trim_s trimIn = '0;
	dcc_supply_s main_supply = 2'b10;
	logic [31:0] seed = 32'h12f9;
	int n_fail = 0, cmp_count = 0, cyc = 0, i;
	always #20 sys_clk = ~sys_clk;
	dcc_code_path #(.N(16)) dcc_code_path_inst (.sys_clk(sys_clk), .rstn(rstn),
		.codeWrite(codeWrite), .outputCode(outputCode), .trimIn(trimIn),
		.spanSelect(spanSelect), .clear_span_select(clear_span_select),
		.clearState(clearState), .safe_state_code(safe_state_code),
		.fault_action_config(fault_action_config), .main_supply(main_supply),
		.convCode(convCode), .convUpdate(convUpdate), .narrowSpan(narrowSpan),
		.supplyAlarm(supplyAlarm), .faultActionOut(faultActionOut), .supplyBand(supplyBand));
	dcc_conv_model dcc_conv_model_inst (.sys_clk(sys_clk), .rstn(rstn), .convUpdate(convUpdate),
		.convCode(convCode), .heldCode(heldCode));
	begin : narrow_variant
		dcc_code_path #(.N(14)) dcc_code_path_inst (.sys_clk(sys_clk), .rstn(rstn),
			.codeWrite(codeWrite), .outputCode(outputCode), .trimIn(trimIn),
			.spanSelect(spanSelect), .clear_span_select(clear_span_select),
			.clearState(clearState), .safe_state_code(safe_state_code),
			.fault_action_config(fault_action_config), .main_supply(main_supply),
			.convCode(convCode14), .convUpdate(), .narrowSpan(), .supplyAlarm(),
			.faultActionOut(), .supplyBand());
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	function automatic logic [15:0] cal(input logic [15:0] dv, gv, ov, input int dr);
		longint v;
		longint top;
		top = (longint'(1) <<< (16 - dr)) - 1;
		v = (longint'(dv >> dr) * (longint'(gv >> dr) + (top + 1) / 2)) >>> (16 - dr);
		v = v + (longint'($signed(ov)) >>> dr);
		if (v < 0) return 16'h0000;
		if (v > top) return top[15:0];
		return v[15:0];
	endfunction : cal
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up;
		if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	task automatic wr(input logic [15:0] dv, input logic [15:0] gv, input logic [15:0] ov);
		trimIn = '{gainTrim: gv, offsetTrim: ov};
		outputCode = dv;
		codeWrite = 1;
		last = cal(dv, gv, ov, 0);
		last14 = cal(dv, gv, ov, 2);
		@(negedge sys_clk);
		codeWrite = 0;
		check(convCode, last);
		check(convCode14, last14);
		check(16'(convUpdate), 16'h0001);
		@(negedge sys_clk);
		check(heldCode, last);
	endtask : wr
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc > 3000) begin
			n_fail++;
			wrap_up();
		end
	end
	initial begin
		repeat (8) @(negedge sys_clk);
		rstn = 1;
		check(convCode, DCC_CODE_RESET);
		wr(16'hffff, 16'hffff, 16'h7fff);
		wr(16'h0001, 16'h0000, 16'h8000);
		wr(16'h8000, DCC_GAIN_UNITY, 16'hfffe);
		for (i = 0; i < 60; i++) begin
			seed = xs(seed);
			d = seed[15:0];
			g = seed[31:16];
			seed = xs(seed);
			wr(d, g, seed[15:0]);
		end
		trimIn = '{gainTrim: 16'h0000, offsetTrim: 16'h0100};
		repeat (2) @(negedge sys_clk);
		check(convCode, last);
		check(convCode14, last14);
		clearState = 1;
		codeWrite = 1;
		@(negedge sys_clk);
		codeWrite = 0;
		check(convCode, safe_state_code);
		check(16'(convUpdate), 16'h0001);
		check(convCode14, safe_state_code >> 2);
		check(16'(narrowSpan), 16'h0001);
		clearState = 0;
		for (i = 0; i < 2; i++) begin
			spanSelect = i[0];
			repeat (2) @(negedge sys_clk);
			check(16'(narrowSpan), 16'(i));
		end
		for (i = 0; i < 4; i++) begin
			main_supply = i[1:0];
			fault_action_config = 2'h3 - i[1:0];
			repeat (4) @(negedge sys_clk);
			check(16'(supplyBand), (i == 2) ? 16'h0 : (i == 1) ? 16'h1 : 16'h2);
			check(16'(supplyAlarm), 16'(i == 0 || i == 3));
			check(16'(faultActionOut), (i == 0 || i == 3) ? 16'(fault_action_config) : 16'h0);
		end
		wrap_up();
	end
endmodule : dcc_code_path_tb
`default_nettype wire

// ### tb/dcc_conv_model.sv
// String converter model: latches each presented code.
// Assumes convUpdate marks a fresh code.
`timescale 1ns/1ns
`default_nettype none
module dcc_conv_model (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic convUpdate,
	input wire logic [15:0] convCode,
	output logic [15:0] heldCode
);
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			heldCode <= 16'h0000;
		end else if (convUpdate) begin
			heldCode <= convCode;
		end
	end
endmodule : dcc_conv_model
`default_nettype wire
